// File: hdl/ctr_pkg.sv
// constants and types for the counter, latch and edge detector block
// Overview of operation
// [RL1] rising edge on port zero sets bit 6
// [RL2] bit 6 with enable bit 3 requests interrupt
// [RL3] any write to 089 clears bit 6
// [RL4] falling edge on port one sets bit 5
// [RL5] bit 5 with enable bit 2 requests interrupt
// [RL6] any write to 08a clears bit 5
// [RL7] count bytes readable at 086, 087, undisturbed
// [RL8] latch write-only at 084 and 085
// [RL9] 088 write loads upper latch, presets counter
// [RL10] decrement at zero reloads latch, no wrap
// [RL11] overflow sets bit 7, enable bit 4 interrupts
// [RL12] low count read or preset clears bit 7
// [RL13] two mode bits pick one of four modes
// [RL14] interval mode counts every clock, pin high
// [RL15] pulse mode toggles pin on overflow, preset
// [RL16] event mode counts counter pin rising edges
// [RL17] width mode counts while counter pin low
// [RL18] reset clears control, pin high, keeps counts
// [RL19] five writable control bits, three status flags
// [RL20] edge detectors always active, half clock rate; the code samples the pins on every clk_sys rising edge
// [RL21] one interrupt line from three enabled sources
// [RL22] pins synchronised, edges from successive samples
package ctr_pkg;
   // cpu addresses of the block
   localparam logic [11:0] ADDR_LATCH_HIGH = 12'h084;
   localparam logic [11:0] ADDR_LATCH_LOW = 12'h085;
   localparam logic [11:0] ADDR_COUNT_HIGH = 12'h086;
   localparam logic [11:0] ADDR_COUNT_LOW = 12'h087;
   localparam logic [11:0] ADDR_PRESET = 12'h088;
   localparam logic [11:0] ADDR_RISE_CLEAR = 12'h089;
   localparam logic [11:0] ADDR_FALL_CLEAR = 12'h08a;
   localparam logic [11:0] ADDR_CONTROL = 12'h08f;
   // control register field positions
   localparam int BIT_OVERFLOW = 7;
   localparam int BIT_RISE_FLAG = 6;
   localparam int BIT_FALL_FLAG = 5;
   localparam int BIT_CTR_IE = 4;
   localparam int BIT_RISE_IE = 3;
   localparam int BIT_FALL_IE = 2;
   localparam int BIT_MODE_HIGH = 1;
   localparam int BIT_MODE_LOW = 0;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'h1f;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // pins idle high behind their pull-ups
   localparam logic PIN_RESET_LEVEL = 1'b1;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // counter modes
   typedef enum logic [1:0] {
      MODE_INTERVAL = 2'b00,
      MODE_PULSE_GEN = 2'b01,
      MODE_EVENT = 2'b10,
      MODE_WIDTH = 2'b11
   } counter_mode_t;
   // input index of the sampled pins
   localparam int PIN_PORT_ZERO = 0;
   localparam int PIN_PORT_ONE = 1;
   localparam int PIN_COUNTER = 2;
   localparam int PIN_COUNT = 3;
endpackage

// File: hdl/edge_sync.sv
// two-stage pin synchroniser with edge detection
module edge_sync
   import ctr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin_async,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic stable;
   logic prev;

   // two flops, then one more for the previous sample
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= PIN_RESET_LEVEL;
         stable <= PIN_RESET_LEVEL;
         prev <= PIN_RESET_LEVEL;
      end else begin
         meta <= pin_async; // RL22
         stable <= meta;
         prev <= stable;
      end
   end

   // compare successive samples, one pulse per transition
   assign level = stable;
   assign rise = stable & ~prev; // RL22
   assign fall = ~stable & prev; // RL22
endmodule

// File: hdl/down_counter.sv
// sixteen-bit down counter with reload latch
module down_counter
   import ctr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic dec_en,
   input wire logic latch_high_wr,
   input wire logic latch_low_wr,
   input wire logic preset_wr,
   input wire logic [7:0] wdata,
   output logic [15:0] count,
   output logic overflow
);
   logic [15:0] latch;

   // reset leaves latch and count alone
   always_ff @(posedge clk_sys) begin
      if (latch_high_wr || preset_wr) begin
         latch[15:8] <= wdata; // RL8 RL9
      end
      if (latch_low_wr) begin
         latch[7:0] <= wdata; // RL8
      end
   end

   // preset wins over counting in the same cycle
   always_ff @(posedge clk_sys) begin
      if (preset_wr) begin
         count <= {wdata, latch[7:0]}; // RL9
      end else if (overflow) begin
         count <= latch; // RL10
      end else if (dec_en) begin
         count <= count - COUNT_ONE;
      end
   end

   // decrement from zero is an overflow
   assign overflow = dec_en && !preset_wr && (count == COUNT_ZERO); // RL10
endmodule

// File: hdl/counter_latch_edge_irq.sv
// counter, latch, edge detect and interrupt request block
module counter_latch_edge_irq
   import ctr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [11:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic irq_n,
   input wire logic port_line_zero,
   input wire logic port_line_one,
   input wire logic counter_pin_in,
   output logic counter_pin_out,
   output logic counter_pin_oe_n
);
   // synchronised pin samples and edges
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_level;
   logic [PIN_COUNT-1:0] pin_rise;
   logic [PIN_COUNT-1:0] pin_fall;

   // control register pieces
   logic [4:0] control_bits;
   logic overflow_flag;
   logic rise_flag;
   logic fall_flag;
   logic [7:0] control_view;
   counter_mode_t mode;

   // decoded cpu strokes
   logic wr_latch_high;
   logic wr_latch_low;
   logic wr_preset;
   logic wr_rise_clear;
   logic wr_fall_clear;
   logic wr_control;
   logic rd_count_low;

   // counter core
   logic dec_en;
   logic [15:0] count;
   logic overflow;
   logic pulse_level;
   logic next_pulse_level;
   logic next_irq;

   // address match used by every decoder
   function automatic logic hit(input logic strobe, input logic [11:0] addr,
                                input logic [11:0] target);
      hit = strobe && (addr == target);
   endfunction

   // pins gathered for the synchroniser loop
   assign pin_raw[PIN_PORT_ZERO] = port_line_zero;
   assign pin_raw[PIN_PORT_ONE] = port_line_one;
   assign pin_raw[PIN_COUNTER] = counter_pin_in;

   // one synchroniser per input pin, always running
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
         edge_sync u_sync (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .pin_async(pin_raw[gi]), // RL20
            .level(pin_level[gi]),
            .rise(pin_rise[gi]),
            .fall(pin_fall[gi])
         );
      end
   endgenerate

   // write and read decoding, data value ignored for commands
   assign wr_latch_high = hit(cpu_wr, cpu_addr, ADDR_LATCH_HIGH); // RL8
   assign wr_latch_low = hit(cpu_wr, cpu_addr, ADDR_LATCH_LOW); // RL8
   assign wr_preset = hit(cpu_wr, cpu_addr, ADDR_PRESET); // RL9
   assign wr_rise_clear = hit(cpu_wr, cpu_addr, ADDR_RISE_CLEAR); // RL3
   assign wr_fall_clear = hit(cpu_wr, cpu_addr, ADDR_FALL_CLEAR); // RL6
   assign wr_control = hit(cpu_wr, cpu_addr, ADDR_CONTROL); // RL19
   assign rd_count_low = hit(cpu_rd, cpu_addr, ADDR_COUNT_LOW); // RL12

   // mode from the two low control bits
   assign mode = counter_mode_t'(control_bits[BIT_MODE_HIGH:BIT_MODE_LOW]); // RL13

   // count source chosen by mode
   always_comb begin
      case (mode)
         MODE_INTERVAL: dec_en = 1'b1; // RL14
         MODE_PULSE_GEN: dec_en = 1'b1; // RL15
         MODE_EVENT: dec_en = pin_rise[PIN_COUNTER]; // RL16
         MODE_WIDTH: dec_en = ~pin_level[PIN_COUNTER]; // RL17
         default: dec_en = 1'b0;
      endcase
   end

   // counter and reload latch
   down_counter u_counter (
      .clk_sys(clk_sys),
      .dec_en(dec_en),
      .latch_high_wr(wr_latch_high),
      .latch_low_wr(wr_latch_low),
      .preset_wr(wr_preset),
      .wdata(cpu_wdata),
      .count(count),
      .overflow(overflow)
   );

   // five writable control bits, cleared at reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         control_bits <= CONTROL_RESET[4:0]; // RL18
      end else if (wr_control) begin
         control_bits <= cpu_wdata[4:0] & CONTROL_WRITE_MASK[4:0]; // RL19
      end
   end

   // overflow flag, a new overflow beats a clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0; // RL18
      end else if (overflow) begin
         overflow_flag <= 1'b1; // RL11
      end else if (rd_count_low || wr_preset) begin
         overflow_flag <= 1'b0; // RL12
      end
   end

   // port zero rising edge flag, set beats clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rise_flag <= 1'b0; // RL18
      end else if (pin_rise[PIN_PORT_ZERO]) begin
         rise_flag <= 1'b1; // RL1
      end else if (wr_rise_clear) begin
         rise_flag <= 1'b0; // RL3
      end
   end

   // port one falling edge flag, set beats clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fall_flag <= 1'b0; // RL18
      end else if (pin_fall[PIN_PORT_ONE]) begin
         fall_flag <= 1'b1; // RL4
      end else if (wr_fall_clear) begin
         fall_flag <= 1'b0; // RL6
      end
   end

   // assembled control register as software sees it
   always_comb begin
      control_view = {3'b000, control_bits};
      control_view[BIT_OVERFLOW] = overflow_flag;
      control_view[BIT_RISE_FLAG] = rise_flag;
      control_view[BIT_FALL_FLAG] = fall_flag;
   end

   // single request from the three enabled sources
   assign next_irq = (control_view[BIT_OVERFLOW] & control_view[BIT_CTR_IE]) // RL11
                   | (control_view[BIT_RISE_FLAG] & control_view[BIT_RISE_IE]) // RL2
                   | (control_view[BIT_FALL_FLAG] & control_view[BIT_FALL_IE]); // RL5

   // interrupt request line, active low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= ~next_irq; // RL21
      end
   end

   // pulse generator toggle state
   always_comb begin
      next_pulse_level = pulse_level;
      if (mode == MODE_PULSE_GEN && (overflow || wr_preset)) begin
         next_pulse_level = ~pulse_level; // RL15
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulse_level <= PIN_RESET_LEVEL;
      end else begin
         pulse_level <= next_pulse_level;
      end
   end

   // counter pin drive: output in modes 0 and 1, input otherwise
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         counter_pin_out <= PIN_RESET_LEVEL; // RL18
         counter_pin_oe_n <= 1'b0;
      end else begin
         case (mode)
            MODE_INTERVAL: begin
               counter_pin_out <= PIN_RESET_LEVEL; // RL14
               counter_pin_oe_n <= 1'b0;
            end
            MODE_PULSE_GEN: begin
               counter_pin_out <= next_pulse_level; // RL15
               counter_pin_oe_n <= 1'b0;
            end
            MODE_EVENT, MODE_WIDTH: begin
               counter_pin_out <= PIN_RESET_LEVEL;
               counter_pin_oe_n <= 1'b1; // RL16 RL17
            end
            default: begin
               counter_pin_out <= PIN_RESET_LEVEL;
               counter_pin_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // read data, registered one cycle after the read strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rdata <= READ_ZERO;
      end else if (cpu_rd) begin
         case (cpu_addr)
            ADDR_COUNT_HIGH: cpu_rdata <= count[15:8]; // RL7
            ADDR_COUNT_LOW: cpu_rdata <= count[7:0]; // RL7
            ADDR_CONTROL: cpu_rdata <= control_view; // RL19
            default: cpu_rdata <= READ_ZERO;
         endcase
      end
   end
endmodule

// File: dv/counter_latch_edge_irq_chk.sv
// port checker for the counter, latch and edge block
module counter_latch_edge_irq_chk
   import ctr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [11:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic irq_n,
   input wire logic port_line_zero,
   input wire logic port_line_one,
   input wire logic counter_pin_out,
   input wire logic counter_pin_oe_n
);
   logic [4:0] ctl;
   // shadow of the writable control bits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) ctl <= 5'h00;
      else if (cpu_wr && cpu_addr == ADDR_CONTROL) ctl <= cpu_wdata[4:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_RESET_OUT: assert property (
      $rose(rst_n) |-> irq_n && counter_pin_out && !counter_pin_oe_n) else $error("reset outputs");
   AST_RISE_IRQ: assert property (
      $rose(port_line_zero) && ctl[3] |-> ##[2:6] !irq_n) else $error("rise irq late");
   AST_FALL_IRQ: assert property (
      $fell(port_line_one) && ctl[2] |-> ##[2:6] !irq_n) else $error("fall irq late");
   AST_IRQ_CAUSE: assert property (
      !irq_n |-> $past(ctl[4:2]) != 3'h0) else $error("irq without enable");
   AST_LATCH_READ: assert property (
      cpu_rd && (cpu_addr == ADDR_LATCH_HIGH || cpu_addr == ADDR_LATCH_LOW)
      |=> cpu_rdata == READ_ZERO) else $error("latch readable");
   AST_INTERVAL_PIN: assert property (
      ctl[1:0] == MODE_INTERVAL ##1 ctl[1:0] == MODE_INTERVAL
      |-> counter_pin_out && !counter_pin_oe_n) else $error("interval pin");
   AST_PRESET_TOGGLE: assert property (
      ctl[1:0] == MODE_PULSE_GEN && cpu_wr && cpu_addr == ADDR_PRESET
      |=> counter_pin_out != $past(counter_pin_out)) else $error("preset toggle");
   AST_READBACK: assert property (
      cpu_rd && cpu_addr == ADDR_CONTROL |=> cpu_rdata[4:0] == $past(ctl))
      else $error("control readback");
endmodule

bind counter_latch_edge_irq counter_latch_edge_irq_chk counter_latch_edge_irq_chk_inst (
   .clk_sys, .rst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .irq_n,
   .port_line_zero, .port_line_one, .counter_pin_out, .counter_pin_oe_n);

// File: dv/pin_source.sv
// event sources on the port lines and the pulled-up counter pin
module pin_source (
   input wire logic clk_sys,
   input wire logic [2:0] want,
   input wire logic counter_pin_out,
   input wire logic counter_pin_oe_n,
   output logic port_line_zero = 1'b1,
   output logic port_line_one = 1'b1,
   output logic counter_pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ctr_drive = 1'b1;
   int gap = 0;
   // pins follow requests off the sampling edge, counter edges spaced
   always @(negedge clk_sys) begin
      port_line_zero <= want[0];
      port_line_one <= want[1];
      gap <= gap + 1;
      if (want[2] != ctr_drive && gap >= 1) begin
         ctr_drive <= want[2];
         gap <= 0;
      end
   end
   // block wins while driving, else source or pull-up
   assign counter_pin_in = counter_pin_oe_n ? ctr_drive : counter_pin_out;
endmodule

// File: dv/counter_latch_edge_irq_test.sv
// self-checking bench for the counter, latch and edge block
module counter_latch_edge_irq_test
   import ctr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] cpu_addr = 12'h000;
   logic cpu_wr = 1'b0;
   logic cpu_rd = 1'b0;
   logic [7:0] cpu_wdata = 8'h00;
   logic [7:0] cpu_rdata;
   logic irq_n, port_line_zero, port_line_one, counter_pin_in;
   logic counter_pin_out, counter_pin_oe_n;
   logic [2:0] want = 3'h7;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   // free-running system clock
   always #10 clk_sys = ~clk_sys;
   counter_latch_edge_irq counter_latch_edge_irq_inst (.clk_sys, .rst_n, .cpu_addr,
      .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .irq_n, .port_line_zero,
      .port_line_one, .counter_pin_in, .counter_pin_out, .counter_pin_oe_n);
   pin_source pin_source_inst (.clk_sys, .want, .counter_pin_out, .counter_pin_oe_n,
      .port_line_zero, .port_line_one, .counter_pin_in);
   task automatic check(string what, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", what, e, g);
         num_errors++;
      end
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(negedge clk_sys);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(negedge clk_sys);
      cpu_wr = 1'b0;
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
      @(negedge clk_sys);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge clk_sys);
      cpu_rd = 1'b0;
      check($sformatf("read %h", a), {8'h00, e & m}, {8'h00, cpu_rdata & m});
   endtask
   task automatic wait_irq(int n);
      repeat (n) if (irq_n !== 1'b0) @(negedge clk_sys);
      check("irq line", 16'h0000, {15'h0000, irq_n});
   endtask
   task automatic t_regs();
      check("pin level", 16'h0001, {15'h0000, counter_pin_out});
      wr(ADDR_LATCH_LOW, 8'h80);
      wr(ADDR_PRESET, 8'h01);
      rd(ADDR_CONTROL, CONTROL_RESET);
      wr(ADDR_CONTROL, 8'hff);
      rd(ADDR_CONTROL, 8'h1f);
      rd(ADDR_LATCH_LOW, 8'h00);
      rd(12'h08b, 8'h00);
   endtask
   task automatic t_interval();
      wr(ADDR_CONTROL, 8'h10);
      wr(ADDR_PRESET, 8'h02);
      rd(ADDR_COUNT_HIGH, 8'h02);
      wait_irq(700);
      rd(ADDR_CONTROL, 8'h90);
      rd(ADDR_COUNT_HIGH, 8'h02);
      rd(ADDR_COUNT_LOW, 8'h00, 8'h00);
      rd(ADDR_CONTROL, 8'h10);
      check("irq idle", 16'h0001, {15'h0000, irq_n});
   endtask
   task automatic t_pulse();
      logic prev;
      int flips;
      flips = 0;
      wr(ADDR_CONTROL, 8'h01);
      wr(ADDR_LATCH_LOW, 8'h03);
      prev = counter_pin_out;
      wr(ADDR_PRESET, 8'h00);
      check("pin toggle", {15'h0000, ~prev}, {15'h0000, counter_pin_out});
      repeat (16) begin
         prev = counter_pin_out;
         @(negedge clk_sys);
         if (counter_pin_out !== prev) flips++;
      end
      check("toggle count", 16'h0004, 16'(flips));
   endtask
   task automatic t_count();
      wr(ADDR_CONTROL, 8'h02);
      wr(ADDR_LATCH_LOW, 8'h05);
      wr(ADDR_LATCH_HIGH, 8'h00);
      wr(ADDR_PRESET, 8'h00);
      repeat (3) begin
         want[2] <= 1'b0;
         repeat (3) @(negedge clk_sys);
         want[2] <= 1'b1;
         repeat (3) @(negedge clk_sys);
      end
      repeat (4) @(negedge clk_sys);
      rd(ADDR_COUNT_LOW, 8'h02);
      wr(ADDR_CONTROL, 8'h03);
      wr(ADDR_PRESET, 8'h00);
      want[2] <= 1'b0;
      repeat (3) @(negedge clk_sys);
      want[2] <= 1'b1;
      repeat (5) @(negedge clk_sys);
      rd(ADDR_COUNT_LOW, 8'h02);
      rd(ADDR_COUNT_LOW, 8'h02);
   endtask
   task automatic t_edges();
      wr(ADDR_CONTROL, 8'h0c);
      want[0] <= 1'b0;
      repeat (6) @(negedge clk_sys);
      rd(ADDR_CONTROL, 8'h0c, 8'h7f);
      want[0] <= 1'b1;
      wait_irq(8);
      rd(ADDR_CONTROL, 8'h4c, 8'h7f);
      wr(ADDR_RISE_CLEAR, 8'h5a);
      rd(ADDR_CONTROL, 8'h0c, 8'h7f);
      want[1] <= 1'b0;
      wait_irq(8);
      rd(ADDR_CONTROL, 8'h2c, 8'h7f);
      wr(ADDR_CONTROL, 8'h08);
      // registered request line follows the new mask one edge later
      @(negedge clk_sys);
      check("irq masked", 16'h0001, {15'h0000, irq_n});
      wr(ADDR_FALL_CLEAR, 8'h00);
      rd(ADDR_CONTROL, 8'h08, 8'h7f);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      t_regs();
      t_interval();
      t_pulse();
      t_count();
      t_edges();
      complete_run();
   end
   // hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         complete_run();
      end
   end
endmodule
